// ### hw/oms_regs.vh
// oms_regs.vh: constants of the operating mode sequencer
// assumes a 100 MHz core clock; included by the sequencer and the bench
`ifndef OMS_REGS_VH
`define OMS_REGS_VH
// clock period in ns
`define OMS_CLK_NS 10
// reset extension 1.0 ms in us, mode timeouts 150 ms in us
`define OMS_RST_EXT_US 1000
`define OMS_NREQ_TO_US 150000
`define OMS_VDDLOW_TO_US 150000
// cycle counts derived from time and clock rate
`define OMS_RST_EXT_CYC ((`OMS_RST_EXT_US * 1000) / `OMS_CLK_NS)
`define OMS_NREQ_TO_CYC ((`OMS_NREQ_TO_US * 1000) / `OMS_CLK_NS)
`define OMS_VDDLOW_TO_CYC ((`OMS_VDDLOW_TO_US * 1000) / `OMS_CLK_NS)
// mode select bit codes
`define OMS_MODE_NORMAL 2'h0
`define OMS_MODE_STOP 2'h1
`define OMS_MODE_SLEEP 2'h2
// interrupt source vector positions
`define OMS_ISR_W 8
`define OMS_ISR_SUV 0
`define OMS_ISR_SOV 1
`define OMS_ISR_OTW 2
`define OMS_ISR_LIN 3
`define OMS_ISR_HSOT 4
`define OMS_ISR_WAKE 5
// wake source vector positions
`define OMS_WK_W 3
`define OMS_WK_L1 0
`define OMS_WK_FORCE 1
`define OMS_WK_LIN 2
// counter width and reset-pin glitch filter length
`define OMS_CNT_W 24
`define OMS_GLITCH_CYC 24'h000010
`endif

// ### hw/oms_sync3.v
// oms_sync3.v: three-stage input synchroniser with agreement filter
// assumes an asynchronous input and a single core clock
`timescale 1ns/1ps
`default_nettype none
module oms_sync3 (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // signal
  input wire din,
  output reg dout_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        dout_q <= s3_q;
      end
    end
  end
endmodule // oms_sync3
`default_nettype wire

// ### hw/oms_timer.v
// oms_timer.v: up counter held at zero while not running, expires after a parameter count
// assumes the same core clock as its user
`timescale 1ns/1ps
`default_nettype none
module oms_timer #(
  parameter [23:0] TERM = 24'h000001
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // control
  input wire run,
  output wire expired
);
  reg [23:0] cnt_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 24'h000000;
    end else if (!run) begin
      cnt_q <= 24'h000000;
    end else if (cnt_q != TERM) begin
      cnt_q <= cnt_q + 24'h000001;
    end
  end
  assign expired = run && (cnt_q == TERM);
endmodule // oms_timer
`default_nettype wire

// ### hw/oms_sequencer.v
// oms_sequencer.v: operating mode sequencer (reset, normal request, normal, stop, sleep)
// assumes pins pass through oms_sync3; spi frames decoded elsewhere into strobes
//
// What this block does
// - power-up enters reset mode, reset line low ~1 ms, then normal request
// - reset mode on regulator low, watchdog fail, sleep wake, request timeout
// - normal request after reset or stop wake; regulator on, reset high, lin rx-only
// - normal request starts 150 ms timer; no normal command means back to reset
// - grounded watchdog config pin skips normal request after reset
// - normal to sleep on sleep command; regulator low goes to reset at once, so its 150 ms timer never expires
// - in reset mode regulator undervoltage without supply undervoltage enters sleep
// - sleep: regulator off; only wake input, forced timer and lin wake active
// - cyclic sense in sleep keeps oscillator on, pulses high side, samples wake input
// - sleep wake goes through reset; wake source readable; battery fail not set
// - stop only by spi command; regulator on with limited current
// - stop wake goes to normal request with interrupt, except chip-select or reset pin
// - in normal modes new interrupts wait until pending wakes are read
// - interrupt line low until interrupt source register read, then high
// - interrupts only in normal, request, stop; never with reset low
// - sources: supply under/over voltage, overtemp warning, lin fault, high side; maskable
// - lin faults disable driver until fault clears and transmit returns recessive
// - reset held while condition lasts, then at least ~1 ms more
// - reset below threshold; regulator overtemp disables regulator and sets flag
// - filtered external reset pin forces reset state, also in stop, no extension
// - no register bit for chip-select or reset-pin wakes; host infers them
`timescale 1ns/1ps
`default_nettype none
`include "oms_regs.vh"
module oms_sequencer #(
  parameter [23:0] RST_EXT_CYC = `OMS_RST_EXT_CYC,
  parameter [23:0] NREQ_TO_CYC = `OMS_NREQ_TO_CYC,
  parameter [23:0] VDDLOW_TO_CYC = `OMS_VDDLOW_TO_CYC
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // analog monitors and pins (asynchronous)
  input wire vdd_below_reset_threshold,
  input wire supply_undervoltage_flag,
  input wire supply_overvoltage_flag,
  input wire regulator_overtemp_warn,
  input wire regulator_overtemp,
  input wire watchdog_config_pin_grounded,
  input wire ext_reset_pin_in,
  input wire chip_select_n_in,
  input wire wake_input,
  input wire lin_wake,
  input wire lin_overtemp,
  input wire txd_dominant_stuck,
  input wire rxd_short,
  input wire txd_in,
  input wire high_side_overtemp,
  // spi-decoded controls (core clock)
  input wire watchdog_fail,
  input wire mode_write,
  input wire [1:0] mode_select_bits,
  input wire timing_control_write,
  input wire cyclic_sense_en,
  input wire forced_wake_expired,
  input wire cyclic_tick,
  input wire [`OMS_ISR_W-1:0] interrupt_mask_reg,
  input wire interrupt_source_read,
  // mode and supply outputs
  output reg [4:0] mode_q,
  output reg regulator_en_q,
  output reg regulator_limited_q,
  output reg lin_rx_only_q,
  output reg lin_driver_en_q,
  output reg lp_osc_en_q,
  output reg high_side_pulse_q,
  // reset pin (open drain)
  output reg reset_pin_out_q,
  output wire reset_pin_oe,
  // interrupt line
  output reg irq_n_q,
  // readable status
  output reg [`OMS_ISR_W-1:0] interrupt_source_reg,
  output reg [`OMS_WK_W-1:0] wake_source_q,
  output reg battery_fail_flag,
  output reg regulator_overtemp_flag
);
  localparam [4:0] ST_RESET = 5'h01;
  localparam [4:0] ST_NREQ = 5'h02;
  localparam [4:0] ST_NORMAL = 5'h04;
  localparam [4:0] ST_STOP = 5'h08;
  localparam [4:0] ST_SLEEP = 5'h10;

  // synchronised pins
  wire vdd_low_s;
  wire suv_s;
  wire sov_s;
  wire otw_s;
  wire ot_s;
  wire wdg_gnd_s;
  wire ext_rst_n_s;
  wire cs_n_s;
  wire wake_s;
  wire lin_wake_s;
  wire lin_ot_s;
  wire txd_stuck_s;
  wire rxd_short_s;
  wire txd_s;
  wire hs_ot_s;
  wire [14:0] pin_raw = {vdd_below_reset_threshold, supply_undervoltage_flag, supply_overvoltage_flag,
    regulator_overtemp_warn, regulator_overtemp, watchdog_config_pin_grounded, ext_reset_pin_in,
    chip_select_n_in, wake_input, lin_wake, lin_overtemp, txd_dominant_stuck, rxd_short, txd_in,
    high_side_overtemp};
  wire [14:0] pin_s;
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi = gi + 1) begin : g_sync
      oms_sync3 u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .din(pin_raw[gi]),
        .dout_q(pin_s[gi])
      );
    end
  endgenerate
  assign {vdd_low_s, suv_s, sov_s, otw_s, ot_s, wdg_gnd_s, ext_rst_n_s, cs_n_s, wake_s, lin_wake_s,
    lin_ot_s, txd_stuck_s, rxd_short_s, txd_s, hs_ot_s} = pin_s;

  // reset pin glitch filter: low must persist a fixed count
  reg [`OMS_CNT_W-1:0] glitch_cnt_q;
  reg ext_rst_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      glitch_cnt_q <= {`OMS_CNT_W{1'b0}};
      ext_rst_q <= 1'b0;
    end else if (ext_rst_n_s || reset_pin_out_q == 1'b0) begin
      // own drive is not an external reset
      glitch_cnt_q <= {`OMS_CNT_W{1'b0}};
      ext_rst_q <= 1'b0;
    end else if (glitch_cnt_q != `OMS_GLITCH_CYC) begin
      glitch_cnt_q <= glitch_cnt_q + 24'h000001;
    end else begin
      ext_rst_q <= 1'b1;
    end
  end

  // edge history
  reg cs_n_d1_q;
  reg wake_d1_q;
  reg wake_sample_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_n_d1_q <= 1'b1;
      wake_d1_q <= 1'b0;
      wake_sample_q <= 1'b0;
    end else begin
      cs_n_d1_q <= cs_n_s;
      wake_d1_q <= wake_s;
      if (cyclic_tick) begin
        wake_sample_q <= wake_s;
      end
    end
  end
  wire cs_rise = cs_n_s && !cs_n_d1_q;
  // cyclic sense compares samples at each tick, else any edge wakes
  wire l1_wake = cyclic_sense_en ? (cyclic_tick && wake_s != wake_sample_q) : (wake_s != wake_d1_q);
  wire [`OMS_WK_W-1:0] wake_ev;
  assign wake_ev[`OMS_WK_L1] = l1_wake;
  assign wake_ev[`OMS_WK_FORCE] = forced_wake_expired && !cyclic_sense_en;
  assign wake_ev[`OMS_WK_LIN] = lin_wake_s;
  wire any_wake = |wake_ev;

  // reset conditions
  wire reset_cond = vdd_low_s || watchdog_fail || ext_rst_q;

  // timers
  reg ext_run_q;
  reg vdd_low_run_q;
  wire ext_done;
  wire nreq_done;
  wire vdd_low_done;
  oms_timer #(.TERM(RST_EXT_CYC)) u_rst_ext (
    .core_clk(core_clk),
    .rst(rst),
    .run(ext_run_q && !reset_cond), // held clear while the cause lasts
    .expired(ext_done)
  );
  oms_timer #(.TERM(NREQ_TO_CYC)) u_nreq (
    .core_clk(core_clk),
    .rst(rst),
    .run(mode_q == ST_NREQ),
    .expired(nreq_done)
  );
  oms_timer #(.TERM(VDDLOW_TO_CYC)) u_vddlow (
    .core_clk(core_clk),
    .rst(rst),
    .run(vdd_low_run_q),
    .expired(vdd_low_done)
  );

  // next mode
  reg [4:0] mode_d;
  reg from_ext_d;
  always @* begin
    mode_d = mode_q;
    from_ext_d = 1'b0;
    case (mode_q)
      ST_RESET: begin
        if (vdd_low_s && !suv_s && !ext_rst_q) begin
          mode_d = ST_SLEEP;
        end else if (reset_cond) begin
          mode_d = ST_RESET;
        end else if (ext_done || (ext_rst_q == 1'b0 && !ext_run_q)) begin
          mode_d = wdg_gnd_s ? ST_NORMAL : ST_NREQ;
        end
      end
      ST_NREQ: begin
        if (reset_cond || nreq_done) begin
          mode_d = ST_RESET;
        end else if (mode_write && mode_select_bits == `OMS_MODE_NORMAL) begin
          mode_d = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (vdd_low_done && !suv_s) begin
          mode_d = ST_SLEEP;
        end else if (reset_cond) begin
          mode_d = ST_RESET;
        end else if (mode_write && mode_select_bits == `OMS_MODE_SLEEP) begin
          mode_d = ST_SLEEP;
        end else if (mode_write && mode_select_bits == `OMS_MODE_STOP) begin
          mode_d = ST_STOP;
        end
      end
      ST_STOP: begin
        if (ext_rst_q) begin
          mode_d = ST_RESET;
          from_ext_d = 1'b1;
        end else if (vdd_low_s) begin
          mode_d = ST_RESET;
        end else if (any_wake || cs_rise) begin
          mode_d = ST_NREQ;
        end
      end
      ST_SLEEP: begin
        if (any_wake) begin
          mode_d = ST_RESET;
        end
      end
      default: begin
        mode_d = ST_RESET;
      end
    endcase
  end

  // mode register, reset extension and regulator-low run
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q <= ST_RESET;
      ext_run_q <= 1'b1; // power-up owes an extension
      vdd_low_run_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      vdd_low_run_q <= (mode_q == ST_NORMAL) && vdd_low_s;
      // every internal entry owes an extension, timed from when the cause clears; the pin owes none
      ext_run_q <= (mode_d == ST_RESET) && !ext_rst_q && !from_ext_d
        && (ext_run_q || mode_q != ST_RESET || reset_cond);
    end
  end

  // supply, lin and reset line
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regulator_en_q <= 1'b1;
      regulator_limited_q <= 1'b0;
      lin_rx_only_q <= 1'b1;
      lp_osc_en_q <= 1'b0;
      high_side_pulse_q <= 1'b0;
      reset_pin_out_q <= 1'b0;
      regulator_overtemp_flag <= 1'b0;
    end else begin
      regulator_en_q <= (mode_d != ST_SLEEP) && !ot_s;
      regulator_limited_q <= (mode_d == ST_STOP);
      lin_rx_only_q <= (mode_d != ST_NORMAL);
      lp_osc_en_q <= (mode_d == ST_SLEEP || mode_d == ST_STOP) && cyclic_sense_en;
      high_side_pulse_q <= (mode_q == ST_SLEEP || mode_q == ST_STOP) && cyclic_sense_en && cyclic_tick;
      reset_pin_out_q <= (mode_d != ST_RESET) && (mode_d != ST_SLEEP);
      if (ot_s) begin
        regulator_overtemp_flag <= 1'b1;
      end else if (interrupt_source_read) begin
        regulator_overtemp_flag <= 1'b0;
      end
    end
  end
  // open drain: drive only the low level
  assign reset_pin_oe = !reset_pin_out_q;

  // lin driver fault latch
  reg lin_fault_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lin_fault_q <= 1'b0;
      lin_driver_en_q <= 1'b0;
    end else begin
      if (lin_ot_s || txd_stuck_s || rxd_short_s) begin
        lin_fault_q <= 1'b1;
      end else if (txd_s) begin
        lin_fault_q <= 1'b0;
      end
      lin_driver_en_q <= (mode_q == ST_NORMAL) && !lin_fault_q && !lin_ot_s && !txd_stuck_s && !rxd_short_s;
    end
  end

  // wake source capture and battery fail
  wire wake_taken = (mode_q == ST_STOP || mode_q == ST_SLEEP) && any_wake;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_source_q <= {`OMS_WK_W{1'b0}};
      battery_fail_flag <= 1'b1;
    end else begin
      if (wake_taken) begin
        wake_source_q <= wake_source_q | wake_ev;
      end else if (interrupt_source_read) begin
        wake_source_q <= {`OMS_WK_W{1'b0}};
      end
      if (interrupt_source_read) begin
        battery_fail_flag <= 1'b0;
      end
    end
  end

  // interrupt sources
  // next mode decides, so no low pulse escapes on the edge that enters reset
  wire irq_mode = (mode_d == ST_NORMAL || mode_d == ST_NREQ || mode_d == ST_STOP) && ext_rst_n_s;
  wire fault_mode = (mode_q == ST_NORMAL || mode_q == ST_NREQ);
  wire wake_pending = |wake_source_q;
  reg [`OMS_ISR_W-1:0] isr_ev;
  always @* begin
    isr_ev = {`OMS_ISR_W{1'b0}};
    isr_ev[`OMS_ISR_SUV] = fault_mode && suv_s;
    isr_ev[`OMS_ISR_SOV] = fault_mode && sov_s;
    isr_ev[`OMS_ISR_OTW] = fault_mode && otw_s;
    isr_ev[`OMS_ISR_LIN] = fault_mode && (lin_ot_s || txd_stuck_s || rxd_short_s);
    isr_ev[`OMS_ISR_HSOT] = fault_mode && hs_ot_s;
    isr_ev[`OMS_ISR_WAKE] = (mode_q == ST_STOP) && any_wake;
  end
  wire [`OMS_ISR_W-1:0] isr_new = isr_ev & ~interrupt_mask_reg & ~interrupt_source_reg;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interrupt_source_reg <= {`OMS_ISR_W{1'b0}};
      irq_n_q <= 1'b1;
    end else begin
      // set wins over read-clear
      if (interrupt_source_read) begin
        interrupt_source_reg <= isr_ev & ~interrupt_mask_reg;
      end else begin
        interrupt_source_reg <= interrupt_source_reg | (isr_ev & ~interrupt_mask_reg);
      end
      if (!irq_mode) begin
        irq_n_q <= 1'b1;
      end else if (interrupt_source_read) begin
        irq_n_q <= 1'b1;
      end else if ((|isr_new) && (!wake_pending || mode_q == ST_STOP)) begin
        irq_n_q <= 1'b0;
      end
    end
  end
endmodule // oms_sequencer
`default_nettype wire

// ### bench/oms_host_model.sv
// oms_host_model.sv: host controller model, mode commands and interrupt acknowledge
// assumes the sequencer's core clock; the bench starts each command with one cmd_go pulse
`timescale 1ns/1ps
`default_nettype none
module oms_host_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bench commands
  input wire logic cmd_go,
  input wire logic [1:0] cmd_bits,
  input wire logic [3:0] ack_dly,
  // device side
  input wire logic irq_n_q,
  output logic timing_control_write,
  output logic mode_write,
  output logic [1:0] mode_select_bits,
  output logic interrupt_source_read
);
  logic [3:0] wait_q;
  logic pend_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timing_control_write <= 1'b0;
      mode_write <= 1'b0;
      mode_select_bits <= 2'h3;
      interrupt_source_read <= 1'b0;
      wait_q <= 4'h0;
      pend_q <= 1'b0;
    end else begin
      // timing register first, mode register on the next cycle
      timing_control_write <= cmd_go;
      mode_write <= timing_control_write;
      // outside a write the select bits keep changing so nothing leans on stale values
      mode_select_bits <= timing_control_write ? cmd_bits : mode_select_bits + 2'h1;
      interrupt_source_read <= 1'b0;
      if (!irq_n_q && !pend_q && !interrupt_source_read) begin
        pend_q <= 1'b1;
        wait_q <= ack_dly;
      end else if (pend_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (pend_q) begin
        interrupt_source_read <= 1'b1;
        pend_q <= 1'b0;
      end
    end
  end
endmodule // oms_host_model
`default_nettype wire

// ### bench/oms_sequencer_props.sv
// oms_sequencer_props.sv: port-level assertions for the operating mode sequencer
// assumes the one-hot mode code and registered outputs; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module oms_sequencer_props #(
  parameter [23:0] RST_EXT_CYC = 24'h000014,
  parameter [23:0] NREQ_TO_CYC = 24'h000032
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched inputs
  input wire logic ext_reset_pin_in,
  input wire logic watchdog_config_pin_grounded,
  input wire logic mode_write,
  input wire logic [1:0] mode_select_bits,
  input wire logic interrupt_source_read,
  // watched outputs
  input wire logic [4:0] mode_q,
  input wire logic regulator_en_q,
  input wire logic lin_rx_only_q,
  input wire logic reset_pin_out_q,
  input wire logic irq_n_q
);
  int unsigned ncnt_q;
  int unsigned rcnt_q;
  logic ext_q;
  // cycles spent in request and reset modes; ext_q marks a reset held by the pin
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ncnt_q <= 0;
      rcnt_q <= 0;
      ext_q <= 1'b0;
    end else begin
      ncnt_q <= (mode_q == 5'h02) ? ncnt_q + 1 : 0;
      rcnt_q <= (mode_q == 5'h01) ? rcnt_q + 1 : 0;
      ext_q <= (mode_q == 5'h01) && (ext_q || !ext_reset_pin_in);
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence go_normal_s;
    mode_q == 5'h02 && mode_write && mode_select_bits == 2'h0;
  endsequence
  sequence reset_exit_s;
    $fell(mode_q == 5'h01) && mode_q != 5'h10;
  endsequence
  rst_line_low_a: assert property (mode_q == 5'h01 |-> !reset_pin_out_q)
    else $error("reset line released during reset mode");
  nreq_outputs_a: assert property (mode_q == 5'h02 |-> reset_pin_out_q && regulator_en_q && lin_rx_only_q)
    else $error("request mode outputs wrong");
  normal_cmd_a: assert property (go_normal_s |=> mode_q == 5'h04)
    else $error("normal command not taken");
  stop_cmd_a: assert property (mode_q == 5'h04 && mode_write && mode_select_bits == 2'h1 |=> mode_q == 5'h08)
    else $error("stop command not taken");
  sleep_cmd_a: assert property (mode_q == 5'h04 && mode_write && mode_select_bits == 2'h2 |=> mode_q == 5'h10)
    else $error("sleep command not taken");
  stop_only_cmd_a: assert property ($rose(mode_q == 5'h08) |-> $past(mode_write && mode_select_bits == 2'h1))
    else $error("stop entered without command");
  reset_ext_a: assert property (reset_exit_s |-> ext_q || rcnt_q >= RST_EXT_CYC - 1)
    else $error("reset mode left before extension");
  wd_skip_a: assert property (reset_exit_s |-> mode_q == (watchdog_config_pin_grounded ? 5'h04 : 5'h02))
    else $error("wrong mode after reset");
  nreq_limit_a: assert property (mode_q == 5'h02 |-> ncnt_q <= NREQ_TO_CYC + 4)
    else $error("request mode outlived its timeout");
  nreq_timeout_a: assert property ($fell(mode_q == 5'h02) && mode_q == 5'h01 |-> ncnt_q >= NREQ_TO_CYC - 2)
    else $error("request timeout too early");
  irq_hold_a: assert property (!irq_n_q && !interrupt_source_read && (mode_q == 5'h02 || mode_q == 5'h04
    || mode_q == 5'h08) |=> !irq_n_q || $changed(mode_q))
    else $error("interrupt released without read");
  irq_ack_a: assert property (!irq_n_q && interrupt_source_read |=> irq_n_q)
    else $error("interrupt not released after read");
  irq_mode_a: assert property ($fell(irq_n_q) |-> reset_pin_out_q && (mode_q & 5'h0E) != 5'h00)
    else $error("interrupt raised in wrong mode");
endmodule // oms_sequencer_props
bind oms_sequencer oms_sequencer_props #(.RST_EXT_CYC(RST_EXT_CYC), .NREQ_TO_CYC(NREQ_TO_CYC)) u_props (.*);
`default_nettype wire

// ### bench/tb_oms_sequencer.sv
// tb_oms_sequencer.sv: self-checking bench for the operating mode sequencer
// assumes shortened timer parameters and the host model for commands and reads
`timescale 1ns/1ps
`default_nettype none
`include "oms_regs.vh"
module tb_oms_sequencer;
  typedef struct {int f; int b; logic m;} oms_row_t;
  localparam logic [23:0] RST_EXT = 24'h000014;
  localparam logic [23:0] NREQ_TO = 24'h000032;
  oms_row_t rows[8] = '{'{0, `OMS_ISR_SUV, 1'b0}, '{1, `OMS_ISR_SOV, 1'b0}, '{2, `OMS_ISR_OTW, 1'b0},
    '{3, `OMS_ISR_LIN, 1'b0}, '{4, `OMS_ISR_LIN, 1'b0}, '{5, `OMS_ISR_LIN, 1'b0}, '{6, `OMS_ISR_HSOT, 1'b0},
    '{0, `OMS_ISR_SUV, 1'b1}};
  logic core_clk = 1'b0, rst = 1'b1, vdd_below_reset_threshold = 1'b0, regulator_overtemp = 1'b0;
  logic watchdog_config_pin_grounded = 1'b0, ext_reset_pin_in = 1'b1, chip_select_n_in = 1'b1;
  logic wake_input = 1'b0, lin_wake = 1'b0, txd_in = 1'b1, watchdog_fail = 1'b0, cyclic_sense_en = 1'b0;
  logic forced_wake_expired = 1'b0, cyclic_tick = 1'b0, cmd_go = 1'b0, hit;
  logic [1:0] cmd_bits = 2'h0, mode_select_bits;
  logic [3:0] ack_dly = 4'h8;
  logic [6:0] flt = 7'h00;
  logic [7:0] interrupt_mask_reg = 8'h00, interrupt_source_reg;
  logic [4:0] mode_q;
  logic [2:0] wake_source_q;
  logic mode_write, timing_control_write, interrupt_source_read, regulator_en_q, regulator_limited_q;
  logic lin_rx_only_q, lin_driver_en_q, lp_osc_en_q, high_side_pulse_q, reset_pin_out_q, reset_pin_oe, irq_n_q;
  logic battery_fail_flag, regulator_overtemp_flag;
  wire supply_undervoltage_flag = flt[0];
  wire supply_overvoltage_flag = flt[1];
  wire regulator_overtemp_warn = flt[2];
  wire lin_overtemp = flt[3];
  wire txd_dominant_stuck = flt[4];
  wire rxd_short = flt[5];
  wire high_side_overtemp = flt[6];
  int failures = 0, comparisons = 0, cyc;
  oms_sequencer #(.RST_EXT_CYC(RST_EXT), .NREQ_TO_CYC(NREQ_TO), .VDDLOW_TO_CYC(24'h000028)) u_oms_sequencer (.*);
  oms_host_model u_oms_host_model (.core_clk(core_clk), .rst(rst), .cmd_go(cmd_go), .cmd_bits(cmd_bits),
    .ack_dly(ack_dly), .irq_n_q(irq_n_q), .timing_control_write(timing_control_write), .mode_write(mode_write),
    .mode_select_bits(mode_select_bits), .interrupt_source_read(interrupt_source_read));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wait_mode(input logic [4:0] m, input int n);
    cyc = 0;
    while (mode_q !== m && cyc < n) begin
      @(negedge core_clk);
      cyc++;
    end
    check("mode", mode_q, m);
    if (mode_q !== m) finish_test();
  endtask
  task automatic wait_irq(input logic lvl, input int n);
    hit = 1'b0;
    for (int i = 0; i < n && !hit; i++) begin
      @(negedge core_clk);
      hit = (irq_n_q === lvl);
    end
  endtask
  task automatic host_cmd(input logic [1:0] b, input logic [4:0] m);
    @(posedge core_clk) begin cmd_bits <= b; cmd_go <= 1'b1; end
    @(posedge core_clk) cmd_go <= 1'b0;
    wait_mode(m, 6);
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check("mode", mode_q, 5'h01);
    check("rst_line", {reset_pin_out_q, reset_pin_oe}, 2'h1);
    check("batt_fail", battery_fail_flag, 1'b1);
    wait_mode(5'h02, 60);
    check("ext_len", cyc >= RST_EXT, 1'b1);
    check("rx_only", lin_rx_only_q, 1'b1);
    wait_mode(5'h01, NREQ_TO + 10);
    check("nreq_len", cyc >= NREQ_TO - 2, 1'b1);
    wait_mode(5'h02, 60);
    host_cmd(2'h0, 5'h04);
    foreach (rows[i]) begin
      @(posedge core_clk) begin
        interrupt_mask_reg <= rows[i].m ? (8'h01 << rows[i].b) : 8'h00;
        flt <= 7'h01 << rows[i].f;
      end
      wait_irq(1'b0, 12);
      check("irq", hit, !rows[i].m);
      check("isr", interrupt_source_reg[rows[i].b], !rows[i].m);
      if (rows[i].b == `OMS_ISR_LIN) check("lin_off", lin_driver_en_q, 1'b0);
      @(posedge core_clk) flt <= 7'h00;
      wait_irq(1'b1, 30);
      check("ack", hit, 1'b1);
      check("lin_on", lin_driver_en_q, 1'b1);
    end
    @(posedge core_clk) regulator_overtemp <= 1'b1;
    repeat (6) @(negedge core_clk);
    check("reg_ot", {regulator_overtemp_flag, regulator_en_q}, 2'h2);
    @(posedge core_clk) regulator_overtemp <= 1'b0;
    @(posedge core_clk) watchdog_fail <= 1'b1;
    @(posedge core_clk) watchdog_fail <= 1'b0;
    wait_mode(5'h01, 8);
    wait_mode(5'h02, 60);
    host_cmd(2'h0, 5'h04);
    host_cmd(2'h1, 5'h08);
    check("limited", regulator_limited_q, 1'b1);
    @(posedge core_clk) wake_input <= 1'b1;
    wait_mode(5'h02, 20);
    wait_irq(1'b0, 10);
    check("wake_irq", hit, 1'b1);
    check("wake_src", wake_source_q[`OMS_WK_L1], 1'b1);
    wait_irq(1'b1, 30);
    host_cmd(2'h0, 5'h04);
    host_cmd(2'h1, 5'h08);
    @(posedge core_clk) chip_select_n_in <= 1'b0;
    // a one-cycle pulse would not survive the pin filter
    repeat (4) @(posedge core_clk);
    chip_select_n_in <= 1'b1;
    wait_mode(5'h02, 20);
    wait_irq(1'b0, 10);
    check("cs_irq", hit, 1'b0);
    check("cs_src", wake_source_q, 3'h0);
    host_cmd(2'h0, 5'h04);
    host_cmd(2'h1, 5'h08);
    @(posedge core_clk) cyclic_sense_en <= 1'b1;
    @(posedge core_clk) cyclic_tick <= 1'b1;
    @(negedge core_clk) check("lp_osc", lp_osc_en_q, 1'b1);
    @(posedge core_clk) cyclic_tick <= 1'b0;
    @(negedge core_clk) check("hs_pulse", high_side_pulse_q, 1'b1);
    wait_mode(5'h02, 4);
    wait_irq(1'b1, 30);
    check("tick_ack", hit, 1'b1);
    host_cmd(2'h0, 5'h04);
    host_cmd(2'h1, 5'h08);
    @(posedge core_clk) ext_reset_pin_in <= 1'b0;
    wait_mode(5'h01, 30);
    @(posedge core_clk) ext_reset_pin_in <= 1'b1;
    wait_mode(5'h02, 12);
    check("no_ext", cyc < RST_EXT, 1'b1);
    check("rst_irq", irq_n_q, 1'b1);
    host_cmd(2'h0, 5'h04);
    host_cmd(2'h2, 5'h10);
    check("reg_off", regulator_en_q, 1'b0);
    @(posedge core_clk) lin_wake <= 1'b1;
    wait_mode(5'h01, 20);
    check("lin_src", wake_source_q[`OMS_WK_LIN], 1'b1);
    check("batt_fail", battery_fail_flag, 1'b0);
    @(posedge core_clk) lin_wake <= 1'b0;
    wait_mode(5'h02, 60);
    host_cmd(2'h0, 5'h04);
    @(posedge core_clk) vdd_below_reset_threshold <= 1'b1;
    wait_mode(5'h10, 80);
    @(posedge core_clk) begin
      vdd_below_reset_threshold <= 1'b0;
      wake_input <= 1'b0;
      cyclic_sense_en <= 1'b0;
    end
    wait_mode(5'h01, 20);
    @(posedge core_clk) begin watchdog_config_pin_grounded <= 1'b1; rst <= 1'b1; end
    @(posedge core_clk) rst <= 1'b0;
    wait_mode(5'h04, 60);
    finish_test();
  end
endmodule // tb_oms_sequencer
`default_nettype wire
